// File: pkg/iop_pkg.sv
// package: register map, field positions and reset values of the port block
package iop_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_P0_IN = 8'h00;
  localparam logic [7:0] OFF_SER_MODE = 8'h04;
  localparam logic [7:0] OFF_P1_OUT = 8'h08;
  localparam logic [7:0] OFF_P1_IN = 8'h0c;
  localparam logic [7:0] OFF_P2_OUT = 8'h10;
  localparam logic [7:0] OFF_P3_OUT = 8'h14;
  localparam logic [7:0] OFF_P45_OUT = 8'h18;
  localparam logic [7:0] OFF_P45_IN = 8'h1c;
  localparam logic [7:0] OFF_P6_OUT = 8'h20;
  localparam logic [7:0] OFF_P6_IN = 8'h24;
  localparam logic [7:0] OFF_P6_DIR = 8'h28;
  localparam logic [7:0] OFF_P7_OUT = 8'h2c;
  localparam logic [7:0] OFF_P7_IN = 8'h30;
  localparam logic [7:0] OFF_PORT_CTRL = 8'h34;
  localparam logic [7:0] OFF_SER_DATA = 8'h38;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h3c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h40;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h44;
  localparam logic [7:0] OFF_EVT_CNT = 8'h48;
  // serial mode register fields
  localparam int SER_MODE_EN_BIT = 0;
  localparam int SER_MODE_CLKOUT_BIT = 1;
  // port control register fields (output enables of ports 1..5 and 7, timer output select)
  localparam int CTRL_P1_OE_BIT = 0;
  localparam int CTRL_P2_OE_BIT = 1;
  localparam int CTRL_P3_OE_BIT = 2;
  localparam int CTRL_P4_OE_BIT = 3;
  localparam int CTRL_P5_OE_BIT = 4;
  localparam int CTRL_P7_OE_BIT = 5;
  localparam int CTRL_TOUT_SEL_BIT = 6;
  localparam int CTRL_WIDTH = 7;
  // interrupt status fields
  localparam int IRQ_A_BIT = 0;
  localparam int IRQ_B_BIT = 1;
  localparam int IRQ_SER_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  // reset values
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [CTRL_WIDTH-1:0] RST_CTRL = 7'h00;
  localparam logic [1:0] RST_SER_MODE = 2'h0;
  // serial shift clock half period in ref_clk cycles
  localparam logic [7:0] SER_HALF_CYCLES = 8'h0a;
  localparam logic [3:0] SER_BITS = 4'h8;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: rtl/iop_ports.sv
// design: eight 4-bit ports, serial lines, external interrupts, axi4-lite regs
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module iop_ports
  import iop_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reset_pin,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port 0 and interrupt pins
  input wire logic [3:0] port0_in,
  output logic ser_clk_o,
  output logic ser_clk_oe,
  output logic ser_data_o,
  output logic ser_data_oe,
  input wire logic ext_irq_b,
  // ports 1..7 pin drivers
  input wire logic [3:0] port1_in,
  output logic [3:0] port1_o,
  output logic [3:0] port1_oe,
  output logic [3:0] port2_o,
  output logic [3:0] port2_oe,
  output logic [3:0] port3_o,
  output logic [3:0] port3_oe,
  input wire logic [3:0] port4_in,
  output logic [3:0] port4_o,
  output logic [3:0] port4_oe,
  input wire logic [3:0] port5_in,
  output logic [3:0] port5_o,
  output logic [3:0] port5_oe,
  input wire logic [3:0] port6_in,
  output logic [3:0] port6_o,
  output logic [3:0] port6_oe,
  input wire logic [3:0] port7_in,
  output logic [3:0] port7_o,
  output logic [3:0] port7_oe,
  // timer and event input
  input wire logic timer_out_pin,
  input wire logic event_clk_in,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // reset: async low reset plus the high-level reset pin, synchronised
  // ----------------------------------------------------------------
  logic rpin_s1_q, rpin_s2_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rpin_s1_q <= 1'b1;
      rpin_s2_q <= 1'b1;
    end else begin
      rpin_s1_q <= reset_pin;
      rpin_s2_q <= rpin_s1_q;
    end
  end
  wire srst = rpin_s2_q;
  // ----------------------------------------------------------------
  // pin input synchronisers (two flops, one generate iteration per input nibble: ports 0,1,4..7 and the irq/timer/event pins)
  // ----------------------------------------------------------------
  logic [3:0] pin_raw [0:6];
  logic [3:0] pin_s1_q [0:6];
  logic [3:0] pin_q [0:6];
  assign pin_raw[0] = port0_in;
  assign pin_raw[1] = port1_in;
  assign pin_raw[2] = port4_in;
  assign pin_raw[3] = port5_in;
  assign pin_raw[4] = port6_in;
  assign pin_raw[5] = port7_in;
  assign pin_raw[6] = {1'b0, event_clk_in, timer_out_pin, ext_irq_b};
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          pin_s1_q[gi] <= RST_NIBBLE;
          pin_q[gi] <= RST_NIBBLE;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_q[gi] <= pin_s1_q[gi];
        end
      end
    end
  endgenerate
  wire irq_a_lvl = pin_q[0][0];
  wire irq_b_lvl = pin_q[6][0];
  wire tout_lvl = pin_q[6][1];
  wire evt_lvl = pin_q[6][2];
  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  // a low ready marks a held item; both held and no answer pending starts the write
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      {awaddr_q, wdata_q, wstrb_q} <= 44'h0;
    end else begin
      if (aw_take) begin
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        s_axi_awready <= 1'b1;
      end
      if (w_take) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        s_axi_wready <= 1'b1;
      end
    end
  end
  wire wr_lane0 = wr_go && wstrb_q[0];
  function automatic logic wr_hit(input logic [7:0] off, input logic [7:0] a);
    wr_hit = (a[7:2] == off[7:2]);
  endfunction
  wire wr_mapped = wr_hit(OFF_SER_MODE, awaddr_q) || wr_hit(OFF_P1_OUT, awaddr_q) ||
    wr_hit(OFF_P2_OUT, awaddr_q) || wr_hit(OFF_P3_OUT, awaddr_q) || wr_hit(OFF_P45_OUT, awaddr_q) ||
    wr_hit(OFF_P6_OUT, awaddr_q) || wr_hit(OFF_P6_DIR, awaddr_q) || wr_hit(OFF_P7_OUT, awaddr_q) ||
    wr_hit(OFF_PORT_CTRL, awaddr_q) || wr_hit(OFF_SER_DATA, awaddr_q) || wr_hit(OFF_IRQ_EN, awaddr_q) ||
    wr_hit(OFF_IRQ_CLR, awaddr_q);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // port latches and modes
  // ----------------------------------------------------------------
  logic [3:0] p1_q, p2_q, p3_q, p4_q, p5_q, p6_q, p6_dir_q, p7_q;
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [1:0] ser_mode_q;
  logic [2:0] irq_en_q;
  logic strobe_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {p1_q, p2_q, p3_q, p4_q, p5_q, p6_q, p7_q} <= 28'h0;
      p6_dir_q <= RST_NIBBLE;
      ctrl_q <= RST_CTRL;
      ser_mode_q <= RST_SER_MODE;
      irq_en_q <= 3'h0;
      strobe_q <= 1'b0;
    end else if (srst) begin
      {p1_q, p2_q, p3_q, p4_q, p5_q, p6_q, p7_q} <= 28'h0;
      p6_dir_q <= RST_NIBBLE;
      ctrl_q <= RST_CTRL;
      ser_mode_q <= RST_SER_MODE;
      irq_en_q <= 3'h0;
      strobe_q <= 1'b0;
    end else begin
      // one-cycle strobe alongside every port 1 data write
      strobe_q <= wr_lane0 && wr_hit(OFF_P1_OUT, awaddr_q);
      if (wr_lane0) begin
        if (wr_hit(OFF_P1_OUT, awaddr_q)) p1_q <= wdata_q[3:0];
        else if (wr_hit(OFF_P2_OUT, awaddr_q)) p2_q <= wdata_q[3:0];
        else if (wr_hit(OFF_P3_OUT, awaddr_q)) p3_q <= wdata_q[3:0];
        else if (wr_hit(OFF_P45_OUT, awaddr_q)) begin
          p4_q <= wdata_q[3:0];
          p5_q <= wdata_q[7:4];
        end
        else if (wr_hit(OFF_P6_OUT, awaddr_q)) p6_q <= wdata_q[3:0];
        else if (wr_hit(OFF_P6_DIR, awaddr_q)) p6_dir_q <= wdata_q[3:0];
        else if (wr_hit(OFF_P7_OUT, awaddr_q)) p7_q <= wdata_q[3:0];
        else if (wr_hit(OFF_PORT_CTRL, awaddr_q)) ctrl_q <= wdata_q[CTRL_WIDTH-1:0];
        else if (wr_hit(OFF_SER_MODE, awaddr_q)) ser_mode_q <= wdata_q[1:0];
        else if (wr_hit(OFF_IRQ_EN, awaddr_q)) irq_en_q <= wdata_q[IRQ_WIDTH-1:0];
      end
    end
  end
  wire ser_on = ser_mode_q[SER_MODE_EN_BIT];
  // ----------------------------------------------------------------
  // serial shifter on port 0 lines 1..3 (clock, data out, data in)
  // ----------------------------------------------------------------
  logic [7:0] sh_q;
  logic [3:0] bits_q;
  logic [7:0] div_q;
  logic phase_q, busy_q, ser_done;
  wire ser_start = wr_lane0 && wr_hit(OFF_SER_DATA, awaddr_q) && ser_on && !busy_q;
  wire half_tick = busy_q && (div_q == SER_HALF_CYCLES - 8'h01);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {sh_q, bits_q, div_q} <= 20'h0;
      phase_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (srst || !ser_on || ser_start) begin
      // a start reloads the shifter; a reset or clearing the serial enable abandons the transfer
      if (ser_start && !srst) sh_q <= wdata_q[7:0];
      {bits_q, div_q} <= 12'h0;
      phase_q <= 1'b0;
      busy_q <= ser_start && !srst;
    end else if (busy_q) begin
      div_q <= half_tick ? 8'h00 : div_q + 8'h01;
      if (half_tick) begin
        phase_q <= !phase_q;
        // falling clock shifts out and samples the input line in the same step
        if (phase_q) begin
          sh_q <= {sh_q[6:0], pin_q[0][3]};
          bits_q <= bits_q + 4'h1;
          if (bits_q == SER_BITS - 4'h1) busy_q <= 1'b0;
        end
      end
    end
  end
  assign ser_done = busy_q && half_tick && phase_q && (bits_q == SER_BITS - 4'h1);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {ser_clk_o, ser_clk_oe, ser_data_o, ser_data_oe} <= 4'ha;
    end else begin
      ser_clk_o <= !(busy_q && !phase_q);
      ser_clk_oe <= ser_on && ser_mode_q[SER_MODE_CLKOUT_BIT] && !srst;
      ser_data_o <= !sh_q[7];
      ser_data_oe <= ser_on && !srst;
    end
  end
  // ----------------------------------------------------------------
  // edge detect, interrupt status, event counter
  // ----------------------------------------------------------------
  logic irq_a_d1_q, irq_b_d1_q, evt_d1_q;
  logic [IRQ_WIDTH-1:0] irq_stat_q;
  logic [7:0] evt_cnt_q;
  wire [IRQ_WIDTH-1:0] irq_set = {ser_done,
                                  irq_b_lvl && !irq_b_d1_q,
                                  irq_a_lvl && !irq_a_d1_q};
  wire irq_clr_wr = wr_lane0 && wr_hit(OFF_IRQ_CLR, awaddr_q);
  wire [IRQ_WIDTH-1:0] irq_clr = irq_clr_wr ? wdata_q[IRQ_WIDTH-1:0] : 3'h0;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {irq_a_d1_q, irq_b_d1_q, evt_d1_q} <= 3'h0;
      irq_stat_q <= 3'h0;
      evt_cnt_q <= 8'h00;
      irq <= 1'b0;
    end else begin
      irq_a_d1_q <= irq_a_lvl;
      irq_b_d1_q <= irq_b_lvl;
      evt_d1_q <= evt_lvl;
      if (srst) begin
        irq_stat_q <= 3'h0;
        evt_cnt_q <= 8'h00;
        irq <= 1'b0;
      end else begin
        // a set in the cycle of its clear wins
        irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        // external events arrive on the crystal-in pin, the out pin is unused
        if (evt_lvl && !evt_d1_q) evt_cnt_q <= evt_cnt_q + 8'h01;
        irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
      end
    end
  end
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {port1_o, port1_oe, port2_o, port2_oe, port3_o, port3_oe, port4_o, port4_oe} <= 32'h0;
      {port5_o, port5_oe, port6_o, port6_oe, port7_o, port7_oe} <= 24'h0;
    end else begin
      port1_o <= p1_q;
      port1_oe <= {4{ctrl_q[CTRL_P1_OE_BIT] && !srst}};
      port2_o <= {p2_q[3:2],
                  ctrl_q[CTRL_TOUT_SEL_BIT] ? tout_lvl : p2_q[1],
                  strobe_q | p2_q[0]};
      port2_oe <= {4{ctrl_q[CTRL_P2_OE_BIT] && !srst}};
      port3_o <= p3_q;
      port3_oe <= {4{ctrl_q[CTRL_P3_OE_BIT] && !srst}};
      port4_o <= p4_q;
      port4_oe <= {4{ctrl_q[CTRL_P4_OE_BIT] && !srst}};
      port5_o <= p5_q;
      port5_oe <= {4{ctrl_q[CTRL_P5_OE_BIT] && !srst}};
      port6_o <= p6_q;
      port6_oe <= srst ? 4'h0 : p6_dir_q;
      port7_o <= p7_q;
      port7_oe <= {4{ctrl_q[CTRL_P7_OE_BIT] && !srst}};
    end
  end
  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:2] == OFF_P0_IN[7:2]) rd_val = {28'h0, ser_on ? {3'h0, pin_q[0][0]} : pin_q[0]};
    else if (s_axi_araddr[7:2] == OFF_SER_MODE[7:2]) rd_val = {30'h0, ser_mode_q};
    else if (s_axi_araddr[7:2] == OFF_P1_OUT[7:2]) rd_val = {28'h0, p1_q};
    else if (s_axi_araddr[7:2] == OFF_P1_IN[7:2]) rd_val = {28'h0, pin_q[1]};
    else if (s_axi_araddr[7:2] == OFF_P2_OUT[7:2]) rd_val = {28'h0, p2_q};
    else if (s_axi_araddr[7:2] == OFF_P3_OUT[7:2]) rd_val = {28'h0, p3_q};
    else if (s_axi_araddr[7:2] == OFF_P45_OUT[7:2]) rd_val = {24'h0, p5_q, p4_q};
    else if (s_axi_araddr[7:2] == OFF_P45_IN[7:2]) rd_val = {24'h0, pin_q[3], pin_q[2]};
    else if (s_axi_araddr[7:2] == OFF_P6_OUT[7:2]) rd_val = {28'h0, p6_q};
    else if (s_axi_araddr[7:2] == OFF_P6_IN[7:2]) rd_val = {28'h0, pin_q[4]};
    else if (s_axi_araddr[7:2] == OFF_P6_DIR[7:2]) rd_val = {28'h0, p6_dir_q};
    else if (s_axi_araddr[7:2] == OFF_P7_OUT[7:2]) rd_val = {28'h0, p7_q};
    else if (s_axi_araddr[7:2] == OFF_P7_IN[7:2]) rd_val = {28'h0, pin_q[5]};
    else if (s_axi_araddr[7:2] == OFF_PORT_CTRL[7:2]) rd_val = {25'h0, ctrl_q};
    else if (s_axi_araddr[7:2] == OFF_SER_DATA[7:2]) rd_val = {23'h0, busy_q, sh_q};
    else if (s_axi_araddr[7:2] == OFF_IRQ_STAT[7:2]) rd_val = {29'h0, irq_stat_q};
    else if (s_axi_araddr[7:2] == OFF_IRQ_EN[7:2]) rd_val = {29'h0, irq_en_q};
    else if (s_axi_araddr[7:2] == OFF_IRQ_CLR[7:2]) rd_val = 32'h0000_0000;
    else if (s_axi_araddr[7:2] == OFF_EVT_CNT[7:2]) rd_val = {24'h0, evt_cnt_q};
    else rd_ok = 1'b0;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// File: test/iop_ports_chk.sv
// checker: bus and pin assertions of the port block
`timescale 1ns/1ps
module iop_ports_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reset_pin,
  // axi handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic ser_clk_o,
  input wire logic ser_clk_oe,
  input wire logic ser_data_oe,
  input wire logic [3:0] port1_o,
  input wire logic [3:0] port2_o,
  input wire logic [3:0] port1_oe,
  input wire logic [3:0] port2_oe,
  input wire logic [3:0] port3_oe,
  input wire logic [3:0] port4_oe,
  input wire logic [3:0] port5_oe,
  input wire logic [3:0] port6_oe,
  input wire logic [3:0] port7_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  b_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  r_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  // ----------------------------------------
  // pins
  // ----------------------------------------
  ser_oe_a: assert property (ser_clk_oe |-> ser_data_oe)
    else $error("serial clock driven without data line");
  ser_low_a: assert property (disable iff (!resetn || reset_pin) $fell(ser_clk_o) |-> !ser_clk_o [*8])
    else $error("serial clock low phase too short");
  // the strobe stands in the cycle of every new port 1 value
  strobe_a: assert property (disable iff (!resetn || reset_pin) $changed(port1_o) |-> port2_o[0])
    else $error("port 1 strobe missing");
  rst_oe_a: assert property ($rose(resetn) |-> {port1_oe, port2_oe, port3_oe, port4_oe, port5_oe, port6_oe,
    port7_oe, ser_clk_oe, ser_data_oe} == 30'h0)
    else $error("drivers on after reset");
  pin_rst_a: assert property (reset_pin [*6] |-> {port1_oe, port3_oe, port5_oe, port6_oe, port7_oe} == 20'h0)
    else $error("reset pin did not release drivers");
endmodule

// File: test/iop_pin_mdl.sv
// partner: peripherals on the port pins and the event pulse source
`timescale 1ns/1ps
module iop_pin_mdl (
  // clock
  input wire logic ref_clk,
  // block drivers: ports 1,4,5,6,7 from low nibble up
  input wire logic [19:0] pin_o,
  input wire logic [19:0] pin_oe,
  // levels the peripherals put on floating lines
  input wire logic [19:0] ext_v,
  // resolved pin levels
  output logic [19:0] pin_lvl,
  // event source
  output logic event_clk_in
);
  // a driven line shows its driver, a floating one the peripheral
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_o[i] : ext_v[i];
    end
  end
  // source sits on the clock-in pin only; oscillator-out stays open
  initial event_clk_in = 1'b0;
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      event_clk_in <= 1'b1;
      repeat (3) @(posedge ref_clk);
      event_clk_in <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule

// File: test/tb_top.sv
// testbench: drives the port block over axi4-lite and its pins
`timescale 1ns/1ps
module tb_top;
  import iop_pkg::*;
  logic ref_clk, resetn, reset_pin, ext_irq_b, timer_out_pin, event_clk_in, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ser_clk_o, ser_clk_oe, ser_data_o, ser_data_oe;
  logic [3:0] port0_in, port1_in, port4_in, port5_in, port6_in, port7_in;
  logic [3:0] port1_o, port2_o, port3_o, port4_o, port5_o, port6_o, port7_o;
  logic [3:0] port1_oe, port2_oe, port3_oe, port4_oe, port5_oe, port6_oe, port7_oe;
  logic [19:0] ext_v, pin_lvl;
  logic [27:0] all_oe;
  int error_cnt, num_checks, cyc, stb_cnt;
  assign {port7_in, port6_in, port5_in, port4_in, port1_in} = pin_lvl;
  assign all_oe = {port7_oe, port6_oe, port5_oe, port4_oe, port3_oe, port2_oe, port1_oe};
  iop_ports i_iop_ports (.ref_clk, .resetn, .reset_pin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port0_in, .ser_clk_o, .ser_clk_oe, .ser_data_o, .ser_data_oe,
    .ext_irq_b, .port1_in, .port1_o, .port1_oe, .port2_o, .port2_oe, .port3_o, .port3_oe, .port4_in,
    .port4_o, .port4_oe, .port5_in, .port5_o, .port5_oe, .port6_in, .port6_o, .port6_oe, .port7_in,
    .port7_o, .port7_oe, .timer_out_pin, .event_clk_in, .irq);
  iop_pin_mdl i_iop_pin_mdl (.ref_clk, .pin_o({port7_o, port6_o, port5_o, port4_o, port1_o}),
    .pin_oe({port7_oe, port6_oe, port5_oe, port4_oe, port1_oe}), .ext_v, .pin_lvl, .event_clk_in);
  // ----------------------------------------
  // common tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    chk(s_axi_rresp, er);
    @(posedge ref_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0] offs[8] = '{OFF_P1_OUT, OFF_P2_OUT, OFF_P3_OUT, OFF_P45_OUT, OFF_P6_DIR, OFF_P7_OUT,
      OFF_PORT_CTRL, OFF_IRQ_EN};
    chk(all_oe, 28'h0);
    foreach (offs[i]) begin
      rd(offs[i], d);
      chk(d, 32'h0);
    end
    rd(8'h4c, d, RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h4c, 32'h1, RESP_SLVERR);
    $display("test regs done");
  endtask
  task automatic t_ports;
    ext_v <= 20'h30000;
    wr(OFF_PORT_CTRL, 32'h3f);
    wr(OFF_P3_OUT, 32'ha);
    wr(OFF_P45_OUT, 32'h5c);
    wr(OFF_P7_OUT, 32'h9);
    wr(OFF_P6_DIR, 32'h5);
    wr(OFF_P6_OUT, 32'hf);
    repeat (2) @(posedge ref_clk);
    chk({port3_oe, port3_o}, 32'hfa);
    chk({port5_o, port4_o}, 32'h5c);
    chk({port7_oe, port7_o}, 32'hf9);
    chk(port6_oe, 32'h5);
    rd(OFF_P6_IN, d);
    chk(d[3:0], 32'h5);
    rd(OFF_P45_IN, d);
    chk(d[7:0], 32'h5c);
    wr(OFF_PORT_CTRL, 32'h0f);
    repeat (2) @(posedge ref_clk);
    chk({port7_oe, port5_oe}, 32'h0);
    rd(OFF_P7_IN, d);
    chk(d[3:0], 32'h3);
    rd(OFF_P45_IN, d);
    chk(d[7:0], 32'h0c);
    $display("test ports done");
  endtask
  task automatic t_strobe;
    logic [3:0] vals[2] = '{4'h6, 4'h9};
    int n;
    foreach (vals[i]) begin
      n = stb_cnt;
      wr(OFF_P1_OUT, {28'h0, vals[i]});
      repeat (8) @(posedge ref_clk);
      chk(stb_cnt - n, 1);
      rd(OFF_P1_IN, d);
      chk(d[3:0], vals[i]);
    end
    $display("test strobe done");
  endtask
  task automatic t_tout;
    wr(OFF_PORT_CTRL, 32'h4f);
    timer_out_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(port2_o[1], 1'b1);
    timer_out_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(port2_o[1], 1'b0);
    wr(OFF_PORT_CTRL, 32'h0f);
    $display("test tout done");
  endtask
  task automatic t_irq;
    wr(OFF_IRQ_EN, 32'h3);
    ext_irq_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(irq, 1'b1);
    rd(OFF_IRQ_STAT, d);
    chk(d[2:0], 32'h2);
    wr(OFF_IRQ_CLR, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    wr(OFF_SER_MODE, 32'h1);
    port0_in <= 4'h1;
    repeat (6) @(posedge ref_clk);
    rd(OFF_IRQ_STAT, d);
    chk(d[2:0], 32'h1);
    wr(OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    wr(OFF_IRQ_CLR, 32'h7);
    ext_irq_b <= 1'b0;
    port0_in <= 4'h0;
    $display("test irq done");
  endtask
  // bits are taken at the rising clock edge and stored inverted
  task automatic t_serial;
    logic [7:0] b;
    logic prev;
    int k;
    prev = 1'b1;
    k = 0;
    wr(OFF_SER_MODE, 32'h3);
    wr(OFF_SER_DATA, 32'ha5);
    for (int n = 0; n < 600 && k < 8; n++) begin
      @(posedge ref_clk);
      if (!prev && ser_clk_o) begin
        b = {b[6:0], ~ser_data_o};
        k++;
      end
      prev = ser_clk_o;
    end
    chk(b, 32'ha5);
    chk({ser_clk_oe, ser_data_oe}, 32'h3);
    repeat (30) @(posedge ref_clk);
    rd(OFF_IRQ_STAT, d);
    chk(d[2], 1'b1);
    wr(OFF_SER_MODE, 32'h0);
    port0_in <= 4'h8;
    repeat (4) @(posedge ref_clk);
    chk(ser_data_oe, 1'b0);
    rd(OFF_P0_IN, d);
    chk(d[3:0], 32'h8);
    $display("test serial done");
  endtask
  task automatic t_event;
    i_iop_pin_mdl.pulse(5);
    repeat (4) @(posedge ref_clk);
    rd(OFF_EVT_CNT, d);
    chk(d[7:0], 32'h5);
    $display("test event done");
  endtask
  task automatic t_rstpin;
    reset_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(all_oe, 28'h0);
    reset_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(OFF_P3_OUT, d);
    chk(d, 32'h0);
    $display("test rstpin done");
  endtask
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    stb_cnt <= stb_cnt + (port2_o[0] === 1'b1);
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    {resetn, reset_pin, ext_irq_b, timer_out_pin, s_axi_awvalid, s_axi_wvalid} = 6'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    port0_in = 4'h0;
    ext_v = 20'h0;
    {error_cnt, num_checks, cyc, stb_cnt} = 128'h0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_ports();
    t_strobe();
    t_tout();
    t_irq();
    t_serial();
    t_event();
    t_rstpin();
    complete_run();
  end
endmodule
bind iop_ports iop_ports_chk i_iop_ports_chk (.ref_clk, .resetn, .reset_pin, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ser_clk_o,
  .ser_clk_oe, .ser_data_oe, .port1_o, .port2_o, .port1_oe, .port2_oe, .port3_oe, .port4_oe,
  .port5_oe, .port6_oe, .port7_oe);
